// >>> core/aiobi_top.sv
`timescale 1ns/10ps
module aiobi_top
(
    // Clock and resets
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_reset_n,
    // Bus control pins
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_start_convert_n,
    input wire logic i_dac_sel,
    input wire logic i_rd_start_mode,
    // Data port
    input wire logic [7:0] i_port_data,
    output logic [7:0] o_port_data,
    output logic o_port_oe,
    // Status pins
    output logic o_busy_n,
    output logic o_done_n,
    // Range and format configuration
    input wire logic i_range_sel,
    input wire logic i_neg_supply,
    output logic o_range_sel,
    output logic o_bipolar,
    // Analog side of the converters
    input wire logic i_cmp_high,
    input wire logic i_conv_clk,
    output logic o_hold,
    output logic [7:0] o_sar_trial,
    output logic [7:0] o_first_dac_holding_reg,
    output logic [7:0] o_second_dac_holding_reg
);

    // ------------------------------------------------------------------
    // Pin synchroniser and edge detection
    // ------------------------------------------------------------------
    aiobi_pkg::aiobi_pins_t pins_raw;
    aiobi_pkg::aiobi_pins_t sync1_q;
    aiobi_pkg::aiobi_pins_t sync2_q;
    aiobi_pkg::aiobi_pins_t prev_q;
    logic [7:0] data_sync1_q;
    logic [7:0] data_sync2_q;

    assign pins_raw = '{cs_n: i_cs_n, rd_n: i_rd_n, wr_n: i_wr_n,
                        start_convert_n: i_start_convert_n, dac_sel: i_dac_sel,
                        range_sel: i_range_sel, neg_supply: i_neg_supply,
                        cmp_high: i_cmp_high, conv_clk: i_conv_clk,
                        rd_start_mode: i_rd_start_mode};

    // Edges are taken only from the second and third stages, so a metastable first stage never reaches logic.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            sync1_q <= aiobi_pkg::PINS_IDLE;
            sync2_q <= aiobi_pkg::PINS_IDLE;
            prev_q <= aiobi_pkg::PINS_IDLE;
            data_sync1_q <= 8'h00;
            data_sync2_q <= 8'h00;
        end
        else
        begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            data_sync1_q <= i_port_data;
            data_sync2_q <= data_sync1_q;
        end
    end

    logic selected;
    logic st_fall;
    logic rd_fall;
    logic rd_rise;
    logic cs_rise;
    logic wr_rise;
    logic conv_tick;
    logic start_evt;

    assign selected = !sync2_q.cs_n;
    assign st_fall = prev_q.start_convert_n && !sync2_q.start_convert_n;
    assign rd_fall = prev_q.rd_n && !sync2_q.rd_n;
    assign rd_rise = !prev_q.rd_n && sync2_q.rd_n;
    assign cs_rise = !prev_q.cs_n && sync2_q.cs_n;
    assign wr_rise = !prev_q.wr_n && sync2_q.wr_n;
    assign conv_tick = !prev_q.conv_clk && sync2_q.conv_clk;
    assign start_evt = st_fall || (rd_fall && selected && sync2_q.rd_start_mode);

    // ------------------------------------------------------------------
    // Range and data format
    // ------------------------------------------------------------------
    // shared range
    assign o_range_sel = sync2_q.range_sel;
    assign o_bipolar = sync2_q.neg_supply;

    // ------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------
    aiobi_pkg::aiobi_state_t state_q;
    logic [7:0] trial_q;
    logic [7:0] mask_q;
    logic [7:0] result_q;
    logic [7:0] trial_d;
    logic conv_end;

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_q <= aiobi_pkg::ST_IDLE;
        end
        else if (!i_nrst)
        begin
            state_q <= aiobi_pkg::ST_IDLE;
        end
        else
        begin
            unique case (state_q)
                aiobi_pkg::ST_IDLE:
                begin
                    if (start_evt)
                    begin
                        state_q <= aiobi_pkg::ST_HOLD;
                    end
                end
                aiobi_pkg::ST_HOLD:
                begin
                    state_q <= aiobi_pkg::ST_CONV;
                end
                aiobi_pkg::ST_CONV:
                begin
                    if (conv_end)
                    begin
                        state_q <= aiobi_pkg::ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= aiobi_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // The comparator is trusted only on conversion clock edges; it settles between them.
    assign conv_end = (state_q == aiobi_pkg::ST_CONV) && conv_tick && (mask_q == aiobi_pkg::SAR_LAST);
    assign trial_d = (sync2_q.cmp_high ? trial_q : (trial_q & ~mask_q)) | (mask_q >> 1);

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            trial_q <= aiobi_pkg::SAR_FIRST;
            mask_q <= aiobi_pkg::SAR_FIRST;
        end
        // The first trial code stands while idle, so the synchronised comparator has settled on it before the first tick.
        else if (state_q != aiobi_pkg::ST_CONV)
        begin
            trial_q <= aiobi_pkg::SAR_FIRST;
            mask_q <= aiobi_pkg::SAR_FIRST;
        end
        else if ((state_q == aiobi_pkg::ST_CONV) && conv_tick)
        begin
            trial_q <= trial_d;
            mask_q <= mask_q >> 1;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            result_q <= aiobi_pkg::RESULT_RST;
        end
        else if (conv_end)
        begin
            result_q <= trial_d;
        end
    end

    assign o_busy_n = !(state_q == aiobi_pkg::ST_CONV);
    assign o_hold = (state_q != aiobi_pkg::ST_IDLE);
    assign o_sar_trial = trial_q;

    // ------------------------------------------------------------------
    // Conversion done flag
    // ------------------------------------------------------------------
    logic done_n_q;

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            done_n_q <= 1'b1;
        end
        else if (!i_nrst)
        begin
            done_n_q <= 1'b1;
        end
        else if (conv_end)
        begin
            done_n_q <= 1'b0;
        end
        else if (cs_rise || rd_rise)
        begin
            done_n_q <= 1'b1;
        end
    end

    assign o_done_n = done_n_q;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [7:0] port_q;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            port_q <= aiobi_pkg::RESULT_RST;
        end
        else
        begin
            port_q <= sync2_q.neg_supply ? (result_q ^ aiobi_pkg::FMT_FLIP) : result_q;
        end
    end

    assign o_port_oe = selected && !sync2_q.rd_n;
    assign o_port_data = port_q;

    // ------------------------------------------------------------------
    // DAC holding registers
    // ------------------------------------------------------------------
    logic [7:0] dac_code;
    logic [7:0] first_q;
    logic [7:0] second_q;

    // Held as offset binary so that the cleared code is zero volts or negative full scale.
    assign dac_code = sync2_q.neg_supply ? (data_sync2_q ^ aiobi_pkg::FMT_FLIP) : data_sync2_q;

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            first_q <= aiobi_pkg::DAC_RST;
            second_q <= aiobi_pkg::DAC_RST;
        end
        else if (!i_nrst)
        begin
            first_q <= aiobi_pkg::DAC_RST;
            second_q <= aiobi_pkg::DAC_RST;
        end
        else if (wr_rise && selected)
        begin
            if (sync2_q.dac_sel)
            begin
                second_q <= dac_code;
            end
            else
            begin
                first_q <= dac_code;
            end
        end
    end

    assign o_first_dac_holding_reg = first_q;
    assign o_second_dac_holding_reg = second_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    busy_in_conv_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst || !i_reset_n)
        !o_busy_n == (state_q == aiobi_pkg::ST_CONV)) else $error("busy does not match conversion");

    start_busy_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst || !i_reset_n)
        (st_fall && state_q == aiobi_pkg::ST_IDLE) |-> ##2 !o_busy_n) else $error("start did not lower busy");

    hold_first_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst || !i_reset_n)
        $fell(o_busy_n) |-> $past(o_hold) && o_hold) else $error("busy fell before hold");

    rd_start_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst || !i_reset_n)
        (rd_fall && selected && sync2_q.rd_start_mode && state_q == aiobi_pkg::ST_IDLE)
        |=> state_q == aiobi_pkg::ST_HOLD) else $error("read did not start conversion");

    done_set_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst || !i_reset_n)
        conv_end |=> !o_done_n && o_busy_n) else $error("done not set at end");

    done_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst || !i_reset_n)
        ((cs_rise || rd_rise) && !conv_end) |=> o_done_n) else $error("done not cleared by strobe");

    reset_clear_a: assert property (@(posedge i_core_clk)
        !i_reset_n |-> (o_done_n && first_q == 8'h00 && second_q == 8'h00)) else $error("reset did not clear");

    first_load_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst || !i_reset_n)
        (wr_rise && selected && !sync2_q.dac_sel) |=> first_q == $past(dac_code) && $stable(second_q))
        else $error("first register load wrong");

    second_load_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst || !i_reset_n)
        (wr_rise && selected && sync2_q.dac_sel) |=> second_q == $past(dac_code) && $stable(first_q))
        else $error("second register load wrong");

    no_select_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst || !i_reset_n)
        !selected |=> $stable(first_q) && $stable(second_q)) else $error("write taken without select");

    port_release_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst || !i_reset_n)
        o_port_oe |-> !sync2_q.cs_n && !sync2_q.rd_n) else $error("port driven without read");

    read_format_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst || !i_reset_n)
        ##1 o_port_data == ($past(sync2_q.neg_supply) ? ($past(result_q) ^ 8'h80) : $past(result_q)))
        else $error("read data format wrong");

    conv_done_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst) $fell(o_done_n));
    dual_write_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
        (wr_rise && selected && !sync2_q.dac_sel) ##[1:200] (wr_rise && selected && sync2_q.dac_sel));
    rd_start_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
        (rd_fall && selected && sync2_q.rd_start_mode && state_q == aiobi_pkg::ST_IDLE));

endmodule // aiobi_top

// >>> dv/aiobi_analog_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Analog front end: conversion clock and ideal comparator
// ------------------------------------------------------------------
module aiobi_analog_model
(
    // Clock
    input wire logic i_clk,
    // Converter side
    input wire logic i_hold,
    input wire logic [7:0] i_trial,
    input wire logic [7:0] i_level,
    // Outputs to the block
    output logic o_conv_clk,
    output logic o_cmp_high
);
    logic [1:0] div_q = 2'h0;
    logic [7:0] held_q = 8'h00;
    logic conv_q = 1'b0;

    // The conversion clock runs free, four core cycles per phase, above the three-cycle minimum.
    always @(posedge i_clk)
    begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3)
        begin
            conv_q <= ~conv_q;
        end
    end

    always @(posedge i_clk)
    begin
        if (!i_hold)
        begin
            held_q <= i_level;
        end
    end

    assign o_conv_clk = conv_q;
    assign o_cmp_high = (held_q >= i_trial);
endmodule // aiobi_analog_model

// >>> dv/aiobi_top_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) \
    begin \
        check_count++; \
        if ((a) !== (e)) \
        begin \
            n_mismatch++; \
            $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (e)); \
        end \
    end
// ------------------------------------------------------------------
// Bench top
// ------------------------------------------------------------------
module aiobi_top_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic reset_n = 1'b1;
    logic cs_n = 1'b1;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic st_n = 1'b1;
    logic dsel = 1'b0;
    logic rmode = 1'b0;
    logic range_sel = 1'b0;
    logic neg = 1'b0;
    logic [7:0] din = 8'h00;
    logic [7:0] level = 8'h00;
    logic [7:0] pdata;
    logic [7:0] trial;
    logic [7:0] dac_a;
    logic [7:0] dac_b;
    logic oe;
    logic busy_n;
    logic done_n;
    logic range_o;
    logic bip;
    logic hold;
    logic cmp;
    logic cclk;
    int n_mismatch = 0;
    int check_count = 0;

    always #50 clk = ~clk;

    aiobi_top u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_reset_n(reset_n), .i_cs_n(cs_n), .i_rd_n(rd_n),
        .i_wr_n(wr_n), .i_start_convert_n(st_n), .i_dac_sel(dsel), .i_rd_start_mode(rmode),
        .i_port_data(din), .o_port_data(pdata), .o_port_oe(oe), .o_busy_n(busy_n), .o_done_n(done_n),
        .i_range_sel(range_sel), .i_neg_supply(neg), .o_range_sel(range_o), .o_bipolar(bip),
        .i_cmp_high(cmp), .i_conv_clk(cclk), .o_hold(hold), .o_sar_trial(trial),
        .o_first_dac_holding_reg(dac_a), .o_second_dac_holding_reg(dac_b));

    aiobi_analog_model u_ana (.i_clk(clk), .i_hold(hold), .i_trial(trial), .i_level(level),
        .o_conv_clk(cclk), .o_cmp_high(cmp));

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Strobes are held four cycles, since the pins need three to pass the synchroniser.
    task automatic wr(input logic sel, input logic [7:0] d);
        dsel = sel;
        din = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        cyc(4);
        wr_n = 1'b1;
        cyc(5);
        cs_n = 1'b1;
        cyc(3);
    endtask

    task automatic rd(input logic [7:0] e);
        cs_n = 1'b0;
        rd_n = 1'b0;
        cyc(4);
        `CHK(oe, 1'b1)
        `CHK(pdata, e)
        cs_n = 1'b1;
        rd_n = 1'b1;
        cyc(4);
        `CHK(oe, 1'b0)
        `CHK(done_n, 1'b1)
    endtask

    task automatic wait_busy(input logic lvl);
        int k;
        k = 0;
        while (busy_n !== lvl && k < 300)
        begin
            cyc(1);
            k++;
        end
        `CHK(busy_n, lvl)
    endtask

    task automatic tally_and_finish();
        if (n_mismatch == 0 && check_count > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    initial
    begin
        #(100 * 5000);
        n_mismatch++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        cyc(12);
        nrst = 1'b1;
        cyc(4);
        `CHK(dac_a, 8'h00)
        `CHK(busy_n, 1'b1)
        `CHK(done_n, 1'b1)
        `CHK(oe, 1'b0)
        `CHK(trial, 8'h80)
        wr(1'b0, 8'h4b);
        `CHK(dac_a, 8'h4b)
        wr(1'b1, 8'hc6);
        `CHK(dac_b, 8'hc6)
        `CHK(dac_a, 8'h4b)
        din = 8'h33;
        wr_n = 1'b0;
        cyc(4);
        wr_n = 1'b1;
        cyc(6);
        `CHK(dac_a, 8'h4b)
        `CHK(dac_b, 8'hc6)
        range_sel = 1'b1;
        neg = 1'b1;
        cyc(3);
        `CHK(range_o, 1'b1)
        `CHK(bip, 1'b1)
        wr(1'b0, 8'h01);
        `CHK(dac_a, 8'h81)
        neg = 1'b0;
        level = 8'hb3;
        cyc(3);
        st_n = 1'b0;
        cyc(4);
        st_n = 1'b1;
        wait_busy(1'b0);
        `CHK(hold, 1'b1)
        wait_busy(1'b1);
        `CHK(done_n, 1'b0)
        rd(8'hb3);
        neg = 1'b1;
        rmode = 1'b1;
        level = 8'h40;
        cyc(3);
        cs_n = 1'b0;
        rd_n = 1'b0;
        wait_busy(1'b0);
        cs_n = 1'b1;
        rd_n = 1'b1;
        rmode = 1'b0;
        wait_busy(1'b1);
        `CHK(done_n, 1'b0)
        reset_n = 1'b0;
        cyc(2);
        `CHK(done_n, 1'b1)
        `CHK(dac_a, 8'h00)
        `CHK(dac_b, 8'h00)
        reset_n = 1'b1;
        cyc(3);
        rd(8'hc0);
        tally_and_finish();
    end
endmodule // aiobi_top_tb

// >>> inc/aiobi_pkg.sv
package aiobi_pkg;

    // ------------------------------------------------------------------
    // Widths, codes and reset values
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MSB_POS = 7;
    localparam int unsigned LSB_POS = 0;
    localparam logic [7:0] DAC_RST = 8'h00;
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [7:0] SAR_FIRST = 8'h80;
    localparam logic [7:0] SAR_LAST = 8'h01;
    localparam logic [7:0] FMT_FLIP = 8'h80;

    // ------------------------------------------------------------------
    // Conversion sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HOLD = 2'b01,
        ST_CONV = 2'b10
    } aiobi_state_t;

    // ------------------------------------------------------------------
    // Pin inputs that pass the synchroniser together
    // ------------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic start_convert_n;
        logic dac_sel;
        logic range_sel;
        logic neg_supply;
        logic cmp_high;
        logic conv_clk;
        logic rd_start_mode;
    } aiobi_pins_t;

    localparam aiobi_pins_t PINS_IDLE = 10'h3c0;

endpackage
